/* File: hw/gpio_pkg.sv */
package gpio_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_A_DATA = 8'h00;
  localparam logic [7:0] ADDR_A_DIR = 8'h04;
  localparam logic [7:0] ADDR_A_PULLUP = 8'h08;
  localparam logic [7:0] ADDR_A_ANALOG = 8'h0C;
  localparam logic [7:0] ADDR_OPTION = 8'h10;
  localparam logic [7:0] ADDR_A_IOC = 8'h14;
  localparam logic [7:0] ADDR_B_DATA = 8'h18;
  localparam logic [7:0] ADDR_B_DIR = 8'h1C;

  // field positions
  localparam int INPUT_ONLY_POS = 5;
  localparam int GLOBAL_PU_DIS_POS = 7;

  // writable masks and pullup / current source pin masks
  localparam logic [7:0] PULLUP_MASK = 8'h2F;
  localparam logic [7:0] ANALOG_MASK = 8'h0F;
  localparam logic [7:0] PULLUP_PIN_MASK = 8'h23;
  localparam logic [7:0] CURSRC_PIN_MASK = 8'h0C;
  localparam logic [7:0] B_IMPL_MASK = 8'hFE;

  // reset values
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] PULLUP_RST = 8'h2F;
  localparam logic [7:0] ANALOG_RST = 8'h0F;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] IOC_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [7:0] a_latch;
    logic [7:0] a_dir;
    logic [7:0] a_pullup;
    logic [7:0] a_analog;
    logic [7:0] option;
    logic [7:0] a_ioc;
    logic [7:0] b_latch;
    logic [7:0] b_dir;
    logic [7:0] a_sync1;
    logic [7:0] a_sync2;
    logic [7:0] b_sync1;
    logic [7:0] b_sync2;
    apb_rsp_s rsp;
    logic [7:0] a_oe;
    logic [7:0] a_out;
    logic [7:0] a_pu_on;
    logic [7:0] a_ibuf_en;
    logic [7:0] a_ioc_live;
    logic [7:0] b_oe;
    logic [7:0] b_out;
  } gpio_state_s;

endpackage

/* File: hw/gpio_port.sv */
// Functional notes
// - first port direction 1 tri-states pin, 0 enables its driver
// - input-only pin 5 direction always reads 1, never writable
// - pullup bits 5,1,0 switch weak pullups on or off
// - bits 3,2 enable current sources, ignoring global pullup disable
// - pin 5 pullup also on when used as master clear
// - unimplemented register bits read as zero
// - analog select bits 3..0 choose analog (1) or digital (0)
// - analog pin loses input buffer, pullup and change interrupt
// - second port is 8-bit register with seven implemented pins
// - second port direction 1 disables driver, 0 enables it
// - data read returns pin levels, write loads output latch
// - data writes are read-modify-write from current pin levels; here a write loads pwdata[7:0] straight into the latch
// - direction still controls drivers on analog pins
// - analog pins read zero through data register
// - driving pins need direction cleared; reads show real pin
// - enabled shared peripheral takes the pin from gpio
// - after reset global pullup disable holds pullups 5,1,0 off; analog reset holds current sources 3,2 off
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpio_port
  import gpio_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire apb_req_s apb_req,
  output var apb_rsp_s apb_rsp,
  // configuration and alternate functions
  input wire logic master_clear_input_enable,
  input wire logic [7:0] a_periph_en,
  input wire logic [7:0] a_periph_oe,
  input wire logic [7:0] a_periph_out,
  input wire logic [7:0] b_periph_en,
  input wire logic [7:0] b_periph_oe,
  input wire logic [7:0] b_periph_out,
  // first port pins
  input wire logic [7:0] a_pin_in,
  output logic [7:0] a_pin_out,
  output logic [7:0] a_pin_oe,
  output logic [7:0] a_pullup_on,
  output logic [7:0] a_input_buf_en,
  output logic [7:0] a_change_irq_live,
  // second port pins
  input wire logic [7:0] b_pin_in,
  output logic [7:0] b_pin_out,
  output logic [7:0] b_pin_oe
);

  gpio_state_s s_q;
  gpio_state_s s_d;

  logic [7:0] a_read;
  logic [7:0] b_read;
  logic [7:0] a_dir_eff;
  logic [7:0] rdata;
  logic hit;
  logic wr;
  logic rd_ok;

  always_comb begin
    s_d = s_q;
    // pins pass two flops before anything reads them
    s_d.a_sync1 = a_pin_in;
    s_d.a_sync2 = s_q.a_sync1;
    s_d.b_sync1 = b_pin_in;
    s_d.b_sync2 = s_q.b_sync1;

    a_read = s_q.a_sync2 & ~s_q.a_analog;
    b_read = s_q.b_sync2 & B_IMPL_MASK;
    a_dir_eff = s_q.a_dir | (8'h01 << INPUT_ONLY_POS);

    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    hit = 1'b1;
    rdata = 8'h00;
    if (apb_req.paddr == ADDR_A_DATA) begin
      rdata = a_read;
    end else if (apb_req.paddr == ADDR_A_DIR) begin
      rdata = a_dir_eff;
    end else if (apb_req.paddr == ADDR_A_PULLUP) begin
      rdata = s_q.a_pullup & PULLUP_MASK;
    end else if (apb_req.paddr == ADDR_A_ANALOG) begin
      rdata = s_q.a_analog & ANALOG_MASK;
    end else if (apb_req.paddr == ADDR_OPTION) begin
      rdata = s_q.option;
    end else if (apb_req.paddr == ADDR_A_IOC) begin
      rdata = s_q.a_ioc;
    end else if (apb_req.paddr == ADDR_B_DATA) begin
      rdata = b_read;
    end else if (apb_req.paddr == ADDR_B_DIR) begin
      rdata = s_q.b_dir & B_IMPL_MASK;
    end else begin
      hit = 1'b0;
    end

    // zero-wait slave: access phase answers in its first cycle
    rd_ok = apb_req.psel & ~apb_req.penable;
    s_d.rsp.pready = rd_ok;
    s_d.rsp.pslverr = rd_ok & ~hit;
    s_d.rsp.prdata = (rd_ok & hit & ~apb_req.pwrite) ? {24'h00_0000, rdata} : 32'h0000_0000;

    if (wr & s_q.rsp.pready & hit) begin
      if (apb_req.paddr == ADDR_A_DATA) begin
        // all eight latch bits load from pwdata[7:0]; none reload from pin levels
        s_d.a_latch = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == ADDR_A_DIR) begin
        s_d.a_dir = apb_req.pwdata[7:0] | (8'h01 << INPUT_ONLY_POS);
      end else if (apb_req.paddr == ADDR_A_PULLUP) begin
        s_d.a_pullup = apb_req.pwdata[7:0] & PULLUP_MASK;
      end else if (apb_req.paddr == ADDR_A_ANALOG) begin
        s_d.a_analog = apb_req.pwdata[7:0] & ANALOG_MASK;
      end else if (apb_req.paddr == ADDR_OPTION) begin
        s_d.option = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == ADDR_A_IOC) begin
        s_d.a_ioc = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == ADDR_B_DATA) begin
        s_d.b_latch = apb_req.pwdata[7:0] & B_IMPL_MASK;
      end else begin
        s_d.b_dir = apb_req.pwdata[7:0] | ~B_IMPL_MASK;
      end
    end

    // pin drive: peripheral takes the pin when enabled, direction gates both peripheral and gpio drive
    for (int i = 0; i < 8; i++) begin
      if (a_periph_en[i]) begin
        s_d.a_oe[i] = a_periph_oe[i] & ~a_dir_eff[i];
        s_d.a_out[i] = a_periph_out[i];
      end else begin
        s_d.a_oe[i] = ~a_dir_eff[i];
        s_d.a_out[i] = s_q.a_latch[i];
      end
      if (b_periph_en[i]) begin
        s_d.b_oe[i] = b_periph_oe[i] & ~s_q.b_dir[i] & B_IMPL_MASK[i];
        s_d.b_out[i] = b_periph_out[i];
      end else begin
        s_d.b_oe[i] = ~s_q.b_dir[i] & B_IMPL_MASK[i];
        s_d.b_out[i] = s_q.b_latch[i];
      end
    end

    // pullups: analog and output pins lose them; current sources skip the global disable
    for (int i = 0; i < 8; i++) begin
      s_d.a_pu_on[i] = 1'b0;
      if (PULLUP_PIN_MASK[i] & ~s_q.a_analog[i] & a_dir_eff[i]) begin
        s_d.a_pu_on[i] = ~s_q.option[GLOBAL_PU_DIS_POS] & s_q.a_pullup[i];
      end
      if (CURSRC_PIN_MASK[i] & ~s_q.a_analog[i] & a_dir_eff[i]) begin
        s_d.a_pu_on[i] = s_q.a_pullup[i];
      end
    end
    if (master_clear_input_enable) begin
      s_d.a_pu_on[INPUT_ONLY_POS] = 1'b1;
    end
    s_d.a_ibuf_en = ~s_q.a_analog;
    s_d.a_ioc_live = s_q.a_ioc & ~s_q.a_analog;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.a_dir <= DIR_RST;
      s_q.b_dir <= DIR_RST;
      s_q.a_pullup <= PULLUP_RST;
      s_q.a_analog <= ANALOG_RST;
      s_q.option <= OPTION_RST;
      s_q.a_ioc <= IOC_RST;
      s_q.a_latch <= LATCH_RST;
      s_q.b_latch <= LATCH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign a_pin_out = s_q.a_out;
  assign a_pin_oe = s_q.a_oe;
  assign a_pullup_on = s_q.a_pu_on;
  assign a_input_buf_en = s_q.a_ibuf_en;
  assign a_change_irq_live = s_q.a_ioc_live;
  assign b_pin_out = s_q.b_out;
  assign b_pin_oe = s_q.b_oe;

endmodule
`default_nettype wire

/* File: tb/gpio_board.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_board (
  // board side of one port
  input wire logic clk,
  input wire logic [7:0] drv_v,
  input wire logic [7:0] drv_en,
  input wire logic [7:0] pu_on,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_v,
  output logic [7:0] pin
);
  logic tog_q = 1'b0;
  // an unpulled, undriven pin wanders so no test leans on a stale level
  always_ff @(posedge clk) tog_q <= ~tog_q;
  always_comb for (int i = 0; i < 8; i++) pin[i] = drv_en[i] ? drv_v[i] : ext_en[i] ? ext_v[i] : pu_on[i] | tog_q;
endmodule
`default_nettype wire

/* File: tb/gpio_port_direction_pullup_analog_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_port_direction_pullup_analog_tb;
  import gpio_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic master_clear_input = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  logic [7:0] a_pen = '0, a_poe = '0, a_pout = '0, a_ext_en = 8'hFF;
  logic [7:0] b_pen = '0, b_poe = '0, b_pout = '0;
  logic [7:0] a_in, a_out, a_oe, a_pu, a_ibuf, a_irq, b_in, b_out, b_oe;
  logic [31:0] rd;
  logic err;
  int bad_count = 0, checks = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  gpio_port dut (.ref_clk(ref_clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .master_clear_input_enable(master_clear_input),
    .a_periph_en(a_pen), .a_periph_oe(a_poe), .a_periph_out(a_pout), .b_periph_en(b_pen),
    .b_periph_oe(b_poe), .b_periph_out(b_pout), .a_pin_in(a_in), .a_pin_out(a_out), .a_pin_oe(a_oe),
    .a_pullup_on(a_pu), .a_input_buf_en(a_ibuf), .a_change_irq_live(a_irq), .b_pin_in(b_in),
    .b_pin_out(b_out), .b_pin_oe(b_oe));
  gpio_board pa (.clk(ref_clk), .drv_v(a_out), .drv_en(a_oe), .pu_on(a_pu), .ext_en(a_ext_en),
    .ext_v(8'hFF), .pin(a_in));
  gpio_board pb (.clk(ref_clk), .drv_v(b_out), .drv_en(b_oe), .pu_on(8'h00), .ext_en(8'hFF),
    .ext_v(8'hA5), .pin(b_in));
  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen with penable
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h00_0000, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rd, {24'h00_0000, e});
  endtask
  // pins pass a two-flop synchroniser, so give them time to land
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(ADDR_A_DIR, 8'hFF);
    rdc(ADDR_A_PULLUP, 8'h2F);
    rdc(ADDR_A_ANALOG, 8'h0F);
    rdc(ADDR_OPTION, OPTION_RST);
    rdc(ADDR_A_IOC, IOC_RST);
    chk(a_pu, 8'h00);
    wr(ADDR_A_ANALOG, 8'hFF);
    rdc(ADDR_A_ANALOG, 8'h0F);
    // analog pins are driven high so a leaking input path would show in the read
    wr(ADDR_A_DATA, 8'h0F);
    wr(ADDR_A_DIR, 8'h00);
    rdc(ADDR_A_DIR, 8'h20);
    settle;
    chk(a_oe, 8'hDF);
    chk(a_out, 8'h0F);
    rdc(ADDR_A_DATA, 8'h20);
    wr(ADDR_A_ANALOG, 8'h00);
    wr(ADDR_A_DATA, 8'h5A);
    settle;
    rdc(ADDR_A_DATA, 8'h7A);
    a_pen <= 8'h40;
    a_poe <= 8'h40;
    settle;
    rdc(ADDR_A_DATA, 8'h3A);
    a_pen <= 8'h00;
    wr(ADDR_A_DIR, 8'hFF);
    a_ext_en <= 8'h00;
    settle;
    chk(a_pu, 8'h0C);
    wr(ADDR_OPTION, 8'h7F);
    wr(ADDR_A_PULLUP, 8'h21);
    settle;
    chk(a_pu, 8'h21);
    wr(ADDR_A_DIR, 8'hFE);
    settle;
    chk(a_pu, 8'h20);
    wr(ADDR_A_DIR, 8'hFF);
    wr(ADDR_A_IOC, 8'hFF);
    wr(ADDR_A_ANALOG, 8'h01);
    settle;
    chk({a_pu, a_ibuf}, 16'h20FE);
    chk(a_irq, 8'hFE);
    master_clear_input <= 1'b1;
    wr(ADDR_A_PULLUP, 8'h00);
    settle;
    chk(a_pu, 8'h20);
    wr(ADDR_B_DIR, 8'h00);
    rdc(ADDR_B_DIR, 8'h00);
    settle;
    chk(b_oe, 8'hFE);
    wr(ADDR_B_DATA, 8'h81);
    b_pen <= 8'h02;
    b_poe <= 8'h02;
    b_pout <= 8'h02;
    settle;
    chk(b_out, 8'h82);
    rdc(ADDR_B_DATA, 8'h82);
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk({rd[31:1], err}, 32'h0000_0001);
    final_report;
  end
endmodule
`default_nettype wire

/* File: tb/gpio_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_port_properties
  import gpio_pkg::*;
(
  // clock, reset, bus
  input wire logic ref_clk,
  input wire logic rstn,
  input wire apb_req_s apb_req,
  input wire apb_rsp_s apb_rsp,
  // pins
  input wire logic master_clear_input_enable,
  input wire logic [7:0] a_pin_oe,
  input wire logic [7:0] a_pullup_on,
  input wire logic [7:0] a_input_buf_en,
  input wire logic [7:0] a_change_irq_live,
  input wire logic [7:0] b_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("no ready");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready held");
  a_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000) else $error("upper");
  a_pullup_output: assert property ((a_pullup_on & a_pin_oe) == 8'h00) else $error("pullup on output");
  a_analog_pullup: assert property ((a_pullup_on[3:0] & ~a_input_buf_en[3:0]) == 4'h0) else $error("analog pu");
  a_analog_irq: assert property ((a_change_irq_live & ~a_input_buf_en) == 8'h00) else $error("analog irq");
  a_b0_undriven: assert property (b_pin_oe[0] == 1'b0) else $error("b0 driven");
  a_master_clear_input_pullup: assert property (master_clear_input_enable |=> a_pullup_on[5]) else $error("master_clear_input pullup");
  cover property (apb_rsp.pslverr);
  cover property (master_clear_input_enable && a_pullup_on[5]);
  cover property (a_pin_oe != 8'h00);
endmodule
bind gpio_port gpio_port_properties u_props (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .master_clear_input_enable(master_clear_input_enable), .a_pin_oe(a_pin_oe), .a_pullup_on(a_pullup_on),
  .a_input_buf_en(a_input_buf_en), .a_change_irq_live(a_change_irq_live), .b_pin_oe(b_pin_oe));
`default_nettype wire
